/* File: shared/pcgb_pkg.sv */
package pcgb_pkg;
    // Register byte offsets
    localparam logic [11:0] RUN_CLOCK_GATE_0_OFFSET = 12'h100;
    localparam logic [11:0] SLEEP_CLOCK_GATE_0_OFFSET = 12'h110;
    localparam logic [11:0] DEEP_SLEEP_CLOCK_GATE_0_OFFSET = 12'h120;
    localparam logic [11:0] RUN_MODE_CLOCK_CONFIG_OFFSET = 12'h130;
    localparam logic [11:0] FAULT_STATUS_OFFSET = 12'h140;
    localparam logic [11:0] FAULT_MASK_OFFSET = 12'h144;

    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 32;
    localparam int NUM_PERIPH = 5;

    // Peripheral indices inside the gate vectors
    localparam int PERIPH_WATCHDOG = 0;
    localparam int PERIPH_HIBERNATION = 1;
    localparam int PERIPH_ADC0 = 2;
    localparam int PERIPH_PWM = 3;
    localparam int PERIPH_CAN_ZERO = 4;

    // Gate, ADC rate and auto-gating select bit positions in the clock registers
    localparam int WATCHDOG_GATE_BIT = 3;
    localparam int HIBERNATION_GATE_BIT = 6;
    localparam int ADC0_GATE_BIT = 16;
    localparam int PWM_GATE_BIT = 20;
    localparam int CAN_CONTROLLER_ZERO_GATE_BIT = 24;
    localparam int ADC_RATE_LSB = 8;
    localparam int ADC_RATE_MSB = 9;
    localparam int AUTO_CLOCK_GATING_SELECT_BIT = 0;

    // Position of each peripheral's gate bit, indexed by peripheral
    localparam int GATE_POS [NUM_PERIPH] = '{
        WATCHDOG_GATE_BIT, HIBERNATION_GATE_BIT, ADC0_GATE_BIT,
        PWM_GATE_BIT, CAN_CONTROLLER_ZERO_GATE_BIT};

    localparam logic [31:0] CLOCK_GATE_RESET = 32'h0000_0040;
    localparam logic [31:0] RUN_SLEEP_WRITE_MASK = 32'h0111_0348;
    localparam logic [31:0] DEEP_SLEEP_WRITE_MASK = 32'h0111_0048;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [NUM_PERIPH-1:0] FAULT_RESET = 5'h00;

    // ADC sample-rate codes
    localparam logic [1:0] ADC_RATE_125K = 2'h0;
    localparam logic [1:0] ADC_RATE_250K = 2'h1;
    localparam logic [1:0] ADC_RATE_500K = 2'h2;
    localparam logic [1:0] ADC_RATE_1M = 2'h3;

    typedef enum logic [2:0] {
        PCGB_RUN = 3'h1,
        PCGB_SLEEP = 3'h2,
        PCGB_DEEP_SLEEP = 3'h4
    } pcgb_power_mode_type;
endpackage

/* File: verilog/pcgb_top.sv */
// Contract
// - Gate bit one clocks peripheral, zero stops.
// - Access to gated peripheral answers bus fault.
// - Gate bits reset to zero unless listed.
// - Three gate registers: run, sleep, deep-sleep.
// - Sleep registers apply only with auto gating.
// - Bits 9:8 pick ADC sample rate.
// - Reserved bits read zero, software preserves them.
// - Bit 16 gates ADC0, resets zero.
// - Bit 3 gates watchdog, resets zero.
// - Bit 6 gates hibernation, resets one.
`timescale 1ns/100ps
`default_nettype none
module pcgb_top (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Power mode, one-hot run/sleep/deep-sleep
    input wire logic [2:0] power_mode_i,
    // Peripheral accesses, one bit per peripheral
    input wire logic [4:0] periph_access_i,
    output logic [4:0] periph_fault_o,
    output logic [4:0] periph_clk_en_o,
    output logic [1:0] adc_sample_rate_o,
    // Interrupt
    output logic irq_o
);
    logic [31:0] run_clock_gate_0;
    logic [31:0] sleep_clock_gate_0;
    logic [31:0] deep_sleep_clock_gate_0;
    logic [31:0] run_mode_clock_config;
    logic [4:0] fault_status;
    logic [4:0] fault_mask;
    logic [31:0] next_rdata;
    logic [31:0] active_gate;
    logic [1:0] next_rate;
    logic [4:0] gated_off;
    logic [4:0] next_fault;
    logic [4:0] fault_status_d;

    wire sel_run = addr_i == pcgb_pkg::RUN_CLOCK_GATE_0_OFFSET;
    wire sel_sleep = addr_i == pcgb_pkg::SLEEP_CLOCK_GATE_0_OFFSET;
    wire sel_deep = addr_i == pcgb_pkg::DEEP_SLEEP_CLOCK_GATE_0_OFFSET;
    wire sel_cfg = addr_i == pcgb_pkg::RUN_MODE_CLOCK_CONFIG_OFFSET;
    wire sel_stat = addr_i == pcgb_pkg::FAULT_STATUS_OFFSET;
    wire sel_mask = addr_i == pcgb_pkg::FAULT_MASK_OFFSET;
    wire auto_clock_gating_select =
        run_mode_clock_config[pcgb_pkg::AUTO_CLOCK_GATING_SELECT_BIT];
    wire [31:0] wr_run = wdata_i & pcgb_pkg::RUN_SLEEP_WRITE_MASK;
    wire [31:0] wr_deep = wdata_i & pcgb_pkg::DEEP_SLEEP_WRITE_MASK;
    wire [4:0] clear_bits = (wr_i && sel_stat) ? wdata_i[4:0] : 5'h00;

    // Mode selection; unknown mode codes fall back to the run register
    always_comb begin
        active_gate = run_clock_gate_0;
        next_rate = run_clock_gate_0[pcgb_pkg::ADC_RATE_MSB:
            pcgb_pkg::ADC_RATE_LSB];
        unique case (pcgb_pkg::pcgb_power_mode_type'(power_mode_i))
            pcgb_pkg::PCGB_RUN: begin
                active_gate = run_clock_gate_0;
            end
            pcgb_pkg::PCGB_SLEEP: begin
                if (auto_clock_gating_select) begin
                    active_gate = sleep_clock_gate_0;
                    next_rate = sleep_clock_gate_0[pcgb_pkg::ADC_RATE_MSB:
                        pcgb_pkg::ADC_RATE_LSB];
                end
            end
            pcgb_pkg::PCGB_DEEP_SLEEP: begin
                if (auto_clock_gating_select) begin
                    active_gate = deep_sleep_clock_gate_0;
                end
            end
            default: begin
                active_gate = run_clock_gate_0;
            end
        endcase
    end

    // Per-peripheral gating and fault detection
    genvar gi;
    generate
        for (gi = 0; gi < pcgb_pkg::NUM_PERIPH; gi++) begin : g_periph
            assign gated_off[gi] = ~active_gate[pcgb_pkg::GATE_POS[gi]];
            assign next_fault[gi] = periph_access_i[gi] & gated_off[gi];
        end
    endgenerate

    // Set wins over a write-one clear in the same cycle
    assign fault_status_d = (fault_status & ~clear_bits) | next_fault;

    assign next_rdata =
        sel_run ? run_clock_gate_0 :
        sel_sleep ? sleep_clock_gate_0 :
        sel_deep ? deep_sleep_clock_gate_0 :
        sel_cfg ? run_mode_clock_config :
        sel_stat ? {27'h0000000, fault_status} :
        sel_mask ? {27'h0000000, fault_mask} :
        32'h0000_0000;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            run_clock_gate_0 <= pcgb_pkg::CLOCK_GATE_RESET;
            sleep_clock_gate_0 <= pcgb_pkg::CLOCK_GATE_RESET;
            deep_sleep_clock_gate_0 <= pcgb_pkg::CLOCK_GATE_RESET;
        end else if (wr_i) begin
            if (sel_run) begin
                run_clock_gate_0 <= wr_run;
            end
            if (sel_sleep) begin
                sleep_clock_gate_0 <= wr_run;
            end
            if (sel_deep) begin
                deep_sleep_clock_gate_0 <= wr_deep;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            run_mode_clock_config <= pcgb_pkg::CONFIG_RESET;
            fault_mask <= pcgb_pkg::FAULT_RESET;
        end else if (wr_i) begin
            if (sel_cfg) begin
                run_mode_clock_config <= {31'h00000000,
                    wdata_i[pcgb_pkg::AUTO_CLOCK_GATING_SELECT_BIT]};
            end
            if (sel_mask) begin
                fault_mask <= wdata_i[4:0];
            end
        end
    end

    // Outputs registered so peripherals see glitch-free enables
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            fault_status <= pcgb_pkg::FAULT_RESET;
            periph_fault_o <= 5'h00;
            periph_clk_en_o <= 5'h02;
            adc_sample_rate_o <= pcgb_pkg::ADC_RATE_125K;
            rdata_o <= 32'h0000_0000;
        end else begin
            fault_status <= fault_status_d;
            periph_fault_o <= next_fault;
            periph_clk_en_o <= ~gated_off;
            adc_sample_rate_o <= next_rate;
            rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
        end
    end

    assign irq_o = |(fault_status & fault_mask);
endmodule
`default_nettype wire

/* File: tb/pcgb_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module pcgb_top_sva (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // Peripheral side
    input wire logic [2:0] power_mode_i,
    input wire logic [4:0] periph_access_i,
    input wire logic [4:0] periph_fault_o,
    input wire logic [4:0] periph_clk_en_o,
    input wire logic [1:0] adc_sample_rate_o,
    input wire logic irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_reset_state: assert property ($rose(rst_n_i) |->
        periph_clk_en_o == 5'h02 && adc_sample_rate_o == 2'h0)
        else $error("outputs wrong after reset");
    // Gate or mode change would race the registered enables
    chk_gated_fault: assert property (!$past(wr_i) &&
        $stable(power_mode_i) |=>
        periph_fault_o == $past(periph_access_i & ~periph_clk_en_o))
        else $error("fault does not follow gated access");
    chk_fault_cause: assert property (
        (periph_fault_o & ~$past(periph_access_i)) == 5'h0)
        else $error("fault without access");
    chk_idle_rdata: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read slot");
    chk_rsvd_zero: assert property ($past(rd_i && addr_i < 12'h130) |->
        (rdata_o & ~32'h01110348) == 32'h0)
        else $error("reserved gate bits not zero");
    chk_deep_norate: assert property ($past(rd_i && addr_i == 12'h120)
        |-> rdata_o[9:8] == 2'h0) else $error("deep rate bits set");
    chk_irq_rise: assert property ($rose(irq_o) |->
        periph_fault_o != 5'h0 || $past(wr_i))
        else $error("irq rose without cause");
    chk_irq_fall: assert property ($fell(irq_o) |-> $past(wr_i))
        else $error("irq fell without write");
    chk_en_cause: assert property (
        $changed({periph_clk_en_o, adc_sample_rate_o}) |-> $past(wr_i, 2)
        || $past(power_mode_i) != $past(power_mode_i, 2))
        else $error("enable changed without cause");
endmodule
bind pcgb_top pcgb_top_sva u_sva (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .power_mode_i(power_mode_i),
    .periph_access_i(periph_access_i), .periph_fault_o(periph_fault_o),
    .periph_clk_en_o(periph_clk_en_o),
    .adc_sample_rate_o(adc_sample_rate_o), .irq_o(irq_o));
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock_i, rst_n_i, wr_i, rd_i, irq_o;
    logic [11:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [2:0] power_mode_i;
    logic [4:0] periph_access_i, periph_fault_o, periph_clk_en_o;
    logic [1:0] adc_sample_rate_o;
    int errors = 0;
    int num_checks = 0;
    pcgb_top u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .power_mode_i(power_mode_i), .periph_access_i(periph_access_i),
        .periph_fault_o(periph_fault_o), .periph_clk_en_o(periph_clk_en_o),
        .adc_sample_rate_o(adc_sample_rate_o), .irq_o(irq_o));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk("rdata_o", e, rdata_o);
    endtask
    // Enables lag the register by one cycle
    task automatic settle(logic [4:0] en);
        repeat (2) @(posedge clock_i);
        #1 chk("clk_en", 32'(en), 32'(periph_clk_en_o));
    endtask
    task automatic acc(logic [4:0] m, logic [4:0] f, logic q);
        @(posedge clock_i);
        periph_access_i <= m;
        @(posedge clock_i);
        periph_access_i <= 5'h0;
        #1 chk("fault", 32'(f), 32'(periph_fault_o));
        chk("irq_o", 32'(q), 32'(irq_o));
    endtask
    task automatic t_gates;
        rd(12'h110, 32'h40);
        rd(12'h120, 32'h40);
        wr(12'h120, 32'hFFFFFFFF);
        rd(12'h120, 32'h01110048);
        wr(12'h100, 32'hFFFFFFFF);
        rd(12'h100, 32'h01110348);
        rd(12'h200, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(12'h100, 32'h1 << pcgb_pkg::GATE_POS[i]);
            settle(5'h1 << i);
        end
        for (int r = 0; r < 4; r++) begin
            wr(12'h100, 32'(r) << 8);
            settle(5'h0);
            chk("rate", 32'(r), 32'(adc_sample_rate_o));
        end
    endtask
    task automatic t_fault;
        acc(5'h1F, 5'h1F, 1'b0);
        rd(12'h140, 32'h1F);
        wr(12'h144, 32'h1F);
        rd(12'h144, 32'h1F);
        acc(5'h0, 5'h0, 1'b1);
        wr(12'h140, 32'h1F);
        wr(12'h100, 32'h01110048);
        acc(5'h1F, 5'h0, 1'b0);
    endtask
    task automatic t_modes;
        wr(12'h110, 32'h00010200);
        wr(12'h120, 32'h01000000);
        power_mode_i <= pcgb_pkg::PCGB_SLEEP;
        settle(5'h1F);
        wr(12'h130, 32'h1);
        settle(5'h04);
        chk("rate", 32'h2, 32'(adc_sample_rate_o));
        rd(12'h130, 32'h1);
        power_mode_i <= pcgb_pkg::PCGB_DEEP_SLEEP;
        settle(5'h10);
    endtask
    task automatic summarize;
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        {rst_n_i, wr_i, rd_i} = 3'h0;
        addr_i = 12'h0;
        wdata_i = 32'h0;
        periph_access_i = 5'h0;
        power_mode_i = 3'h1;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        settle(5'h02);
        t_gates();
        t_fault();
        t_modes();
        summarize();
    end
endmodule
`default_nettype wire
